// ===== hdl/dac_serial_config_port.sv
// serial configuration port: link-side register file and core-side mirror
//
// Overview of operation
// (R01) first eight rising serial-clock edges of each cycle shift in the instruction
// (R02) instruction gives direction, byte count and starting register address
// (R03) remaining edges form the data phase of one to four bytes
// (R04) a written register updates at the last bit of each data byte
// (R05) host pulses reset/mode pin high at least 50 ns, then low
// (R06) reset pulse returns sequencing to the instruction phase unconditionally
// (R07) reset pulse mid-transfer discards partial data, writes nothing
// (R08) data in both directions shares one bidirectional data pin
// (R09) host pulses reset/mode pin after power-up; pin mode may hold it high
// (R10) every configuration register can be read and written
// (R11) host should prefer multibyte transfers over single-byte ones
// (R12) instruction: bit 7 read flag, bits 6:5 count minus one, 4:0 address
// (R13) address decrements per byte in msb-first order, increments in lsb-first
// (R14) sample data on rising edge, drive read data on falling edge, 20 MHz max
// (R15) chip select low for whole cycle; data pin released while high
// (R16) chip select high abandons cycle; next assertion starts a new instruction
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_cfg.svh"

module dac_serial_config_port
   import serial_port_pkg::*;
#(
   parameter int NUM_REGS = 32
) (
   // core clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  reset_n_i,
   // serial link
   input  wire logic                  spi_sclk_i,
   input  wire logic                  spi_cs_n_i,
   input  wire logic                  sdio_i,
   output logic                       sdio_o,
   output logic                       sdio_oe_n_o,
   // reset and mode pin
   input  wire logic                  reset_or_pin_mode_select_i,
   // core-side configuration
   output logic [NUM_REGS-1:0][7:0]   config_regs_o,
   output logic                       lsb_first_order_select_o,
   output logic                       strap_operation_mode_o,
   output logic                       write_strobe_o,
   output logic [4:0]                 write_addr_o
);

   if (NUM_REGS != 32) begin : g_bad_num_regs
      $error("NUM_REGS must equal the 5-bit address space of 32");
   end

   // ***************************************************************
   // link domain: asynchronous clears
   // ***************************************************************
   logic       seq_clear;
   logic       regs_clear;

   // (R06) pin pulse clears sequencing
   // (R16) chip select high abandons the cycle
   assign seq_clear  = spi_cs_n_i | reset_or_pin_mode_select_i;
   assign regs_clear = reset_or_pin_mode_select_i;

   // ***************************************************************
   // link domain: sequencing on rising edge
   // ***************************************************************
   phase_e     phase_reg;
   phase_e     phase_next;
   logic [2:0] bit_cnt_reg;
   logic [2:0] bit_cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic       is_read_reg;
   logic       is_read_next;
   logic [1:0] left_reg;
   logic [1:0] left_next;
   logic [4:0] addr_reg;
   logic [4:0] addr_next;
   logic [7:0] byte_in;
   logic       lsb_first;
   logic       byte_done;
   logic       wr_now;

   logic [7:0] regs_reg  [NUM_REGS];
   logic [7:0] regs_next [NUM_REGS];
   wr_word_s   wr_word_reg;
   wr_word_s   wr_word_next;
   logic       wr_tog_reg;
   logic       wr_tog_next;

   assign lsb_first = regs_reg[`CTRL_ADDR][`CTRL_LSB_FIRST_BIT];
   assign byte_done = (bit_cnt_reg == `BIT_CNT_LAST);

   always_comb begin
      phase_next   = phase_reg;
      is_read_next = is_read_reg;
      left_next    = left_reg;
      addr_next    = addr_reg;
      wr_now       = 1'b0;
      // (R14) data sampled on rising edge, in the selected bit order
      byte_in      = lsb_first ? {sdio_i, shift_reg[7:1]} : {shift_reg[6:0], sdio_i};
      shift_next   = byte_in;
      // wraps to zero after the eighth bit of each byte
      bit_cnt_next = bit_cnt_reg + `BIT_STEP;
      unique case (phase_reg)
         PH_INSTR: begin
            // (R01) eighth rising edge completes the instruction
            if (byte_done) begin
               // (R12) decode direction, count and address
               // (R02) instruction sets up the data phase
               is_read_next = byte_in[`INSTR_DIR_BIT];
               left_next    = byte_in[`INSTR_CNT_HI_BIT:`INSTR_CNT_LO_BIT];
               addr_next    = byte_in[`INSTR_ADDR_HI_BIT:`INSTR_ADDR_LO_BIT];
               phase_next   = PH_DATA;
            end
         end
         PH_DATA: begin
            // (R03) count down one to four data bytes
            if (byte_done) begin
               wr_now    = !is_read_reg;
               // (R13) address walks down for msb first, up for lsb first
               addr_next = lsb_first ? addr_reg + `ADDR_STEP : addr_reg - `ADDR_STEP;
               if (left_reg == `BYTES_LEFT_NONE) begin
                  phase_next = PH_DONE;
               end else begin
                  left_next = left_reg - 2'h1;
               end
            end
         end
         PH_DONE: begin
            phase_next = PH_DONE;
         end
      endcase
   end

   always_ff @(posedge spi_sclk_i or posedge seq_clear) begin
      if (seq_clear) begin
         phase_reg   <= PH_INSTR;
         bit_cnt_reg <= `BIT_CNT_FIRST;
         shift_reg   <= 8'h00;
         is_read_reg <= 1'b0;
         left_reg    <= `BYTES_LEFT_NONE;
         addr_reg    <= 5'h00;
      end else begin
         phase_reg   <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
         is_read_reg <= is_read_next;
         left_reg    <= left_next;
         addr_reg    <= addr_next;
      end
   end

   // ***************************************************************
   // link domain: register file
   // ***************************************************************
   always_comb begin
      regs_next    = regs_reg;
      wr_word_next = wr_word_reg;
      wr_tog_next  = wr_tog_reg;
      // (R04) register takes the byte on its last bit
      // (R10) any address can be written
      if (wr_now) begin
         if (addr_reg == `CTRL_ADDR && byte_in[`CTRL_SOFT_RST_BIT]) begin
            for (int i = 0; i < NUM_REGS; i++) begin
               regs_next[i] = `REG_DEFAULT;
            end
         end
         regs_next[addr_reg] = byte_in;
         if (addr_reg == `CTRL_ADDR) begin
            regs_next[addr_reg][`CTRL_SOFT_RST_BIT] = 1'b0;
         end
         wr_word_next = '{addr: addr_reg, data: byte_in};
         wr_tog_next  = !wr_tog_reg;
      end
   end

   // (R07) pin pulse restores defaults; nothing partial is stored
   always_ff @(posedge spi_sclk_i or posedge regs_clear) begin
      if (regs_clear) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_reg[i] <= `REG_DEFAULT;
         end
         wr_word_reg <= '0;
         wr_tog_reg  <= 1'b0;
      end else begin
         regs_reg    <= regs_next;
         wr_word_reg <= wr_word_next;
         wr_tog_reg  <= wr_tog_next;
      end
   end

   // ***************************************************************
   // link domain: read data on falling edge
   // ***************************************************************
   logic [7:0] tx_byte;
   logic       sdio_next;
   logic       oe_n_next;
   logic       sdio_reg;
   logic       oe_n_reg;

   always_comb begin
      // (R10) any address can be read
      tx_byte   = regs_reg[addr_reg];
      // (R14) read bit driven on falling edge
      sdio_next = lsb_first ? tx_byte[bit_cnt_reg] : tx_byte[`BIT_CNT_LAST - bit_cnt_reg];
      // (R08) same pin turns round for read data
      oe_n_next = !(phase_reg == PH_DATA && is_read_reg);
   end

   // (R15) pin released whenever chip select is high
   always_ff @(negedge spi_sclk_i or posedge seq_clear) begin
      if (seq_clear) begin
         sdio_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         sdio_reg <= sdio_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign sdio_o      = sdio_reg;
   assign sdio_oe_n_o = oe_n_reg;

   // ***************************************************************
   // core domain: crossing and mirror
   // ***************************************************************
   logic       pin_sync;
   logic       tog_sync;

   sync3 u_pin_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (reset_or_pin_mode_select_i),
      .level_o   (pin_sync)
   );

   sync3 u_tog_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (wr_tog_reg),
      .level_o   (tog_sync)
   );

   logic [NUM_REGS-1:0][7:0] mirror_reg;
   logic [NUM_REGS-1:0][7:0] mirror_next;
   logic                     seen_reg;
   logic                     seen_next;
   logic                     strobe_reg;
   logic                     strobe_next;
   logic [4:0]               waddr_reg;
   logic [4:0]               waddr_next;

   always_comb begin
      mirror_next = mirror_reg;
      seen_next   = tog_sync;
      strobe_next = 1'b0;
      waddr_next  = waddr_reg;
      if (pin_sync) begin
         // (R07) drop events while the pin pulse is seen
         mirror_next = '{default: `REG_DEFAULT};
      end else if (tog_sync != seen_reg) begin
         // word held stable for a whole byte time
         if (wr_word_reg.addr == `CTRL_ADDR && wr_word_reg.data[`CTRL_SOFT_RST_BIT]) begin
            mirror_next = '{default: `REG_DEFAULT};
         end
         mirror_next[wr_word_reg.addr] = wr_word_reg.data;
         if (wr_word_reg.addr == `CTRL_ADDR) begin
            mirror_next[wr_word_reg.addr][`CTRL_SOFT_RST_BIT] = 1'b0;
         end
         strobe_next = 1'b1;
         waddr_next  = wr_word_reg.addr;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mirror_reg <= '{default: `REG_DEFAULT};
         seen_reg   <= 1'b0;
         strobe_reg <= 1'b0;
         waddr_reg  <= 5'h00;
      end else begin
         mirror_reg <= mirror_next;
         seen_reg   <= seen_next;
         strobe_reg <= strobe_next;
         waddr_reg  <= waddr_next;
      end
   end

   assign config_regs_o            = mirror_reg;
   assign lsb_first_order_select_o = mirror_reg[`CTRL_ADDR][`CTRL_LSB_FIRST_BIT];
   assign strap_operation_mode_o   = pin_sync;
   assign write_strobe_o           = strobe_reg;
   assign write_addr_o             = waddr_reg;

endmodule : dac_serial_config_port

`default_nettype wire

// ===== hdl/serial_port_cfg.svh
// constants for the converter serial configuration port
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// ***************************************************************
// instruction byte layout
// ***************************************************************
`define INSTR_DIR_BIT      7
`define INSTR_CNT_HI_BIT   6
`define INSTR_CNT_LO_BIT   5
`define INSTR_ADDR_HI_BIT  4
`define INSTR_ADDR_LO_BIT  0

// ***************************************************************
// port control register
// ***************************************************************
`define CTRL_ADDR          5'h00
`define CTRL_LSB_FIRST_BIT 6
`define CTRL_SOFT_RST_BIT  5

// ***************************************************************
// defaults and counts
// ***************************************************************
`define REG_DEFAULT        8'h00
`define BIT_CNT_FIRST      3'h0
`define BIT_CNT_LAST       3'h7
`define BYTES_LEFT_NONE    2'h0
`define ADDR_STEP          5'h01
`define BIT_STEP           3'h1

`endif

// ===== hdl/serial_port_pkg.sv
// types shared by the serial configuration port
package serial_port_pkg;

   // ***************************************************************
   // link sequencing
   // ***************************************************************
   typedef enum logic [2:0] {
      PH_INSTR = 3'b001,
      PH_DATA  = 3'b010,
      PH_DONE  = 3'b100
   } phase_e;

   // ***************************************************************
   // one completed write byte, passed to the core clock
   // ***************************************************************
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] data;
   } wr_word_s;

endpackage : serial_port_pkg

// ===== hdl/sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sync3 (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // level in and out
   input  wire logic async_i,
   output logic      level_o
);

   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       level_reg;
   logic       level_next;

   always_comb begin
      stage_next = {stage_reg[1:0], async_i};
      level_next = level_reg;
      // change counts once stages two and three agree
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         stage_reg <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_o = level_reg;

endmodule : sync3

`default_nettype wire

// ===== test/dac_serial_config_port_chk.sv
// pin-level checker for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module dac_serial_config_port_chk
   import serial_port_pkg::*;
#(parameter int NUM_REGS = 32) (
   // clock, reset, link
   input wire logic                     clk_i,
   input wire logic                     reset_n_i,
   input wire logic                     spi_sclk_i,
   input wire logic                     spi_cs_n_i,
   input wire logic                     sdio_i,
   input wire logic                     sdio_o,
   input wire logic                     sdio_oe_n_o,
   input wire logic                     reset_or_pin_mode_select_i,
   // core side
   input wire logic [NUM_REGS-1:0][7:0] config_regs_o,
   input wire logic                     lsb_first_order_select_o,
   input wire logic                     strap_operation_mode_o,
   input wire logic                     write_strobe_o,
   input wire logic [4:0]               write_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_cs_idle; spi_cs_n_i [*2]; endsequence
   sequence s_pin_hi; reset_or_pin_mode_select_i [*2]; endsequence
   sequence s_pin_long; reset_or_pin_mode_select_i [*8]; endsequence
   property p_oe_idle; s_cs_idle |-> sdio_oe_n_o; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("pin driven while deselected");
   property p_oe_pin; s_pin_hi |-> sdio_oe_n_o; endproperty
   a_oe_pin: assert property (p_oe_pin) else $error("pin driven during reset pulse");
   property p_drv_edge; $fell(sdio_oe_n_o) |-> !spi_cs_n_i && !spi_sclk_i; endproperty
   a_drv_edge: assert property (p_drv_edge) else $error("drive began off falling edge");
   property p_bit_edge; !sdio_oe_n_o && $changed(sdio_o) |-> !spi_sclk_i; endproperty
   a_bit_edge: assert property (p_bit_edge) else $error("read bit moved off falling edge");
   property p_stb_one; write_strobe_o |=> !write_strobe_o; endproperty
   a_stb_one: assert property (p_stb_one) else $error("write strobe longer than one cycle");
   property p_lsb;
      $changed(config_regs_o[0][6]) |=> lsb_first_order_select_o == $past(config_regs_o[0][6]);
   endproperty
   a_lsb: assert property (p_lsb) else $error("order select differs from its register");
   property p_strap; s_pin_long |-> strap_operation_mode_o; endproperty
   a_strap: assert property (p_strap) else $error("mode level not reported");
   property p_drop; strap_operation_mode_o |-> !write_strobe_o; endproperty
   a_drop: assert property (p_drop) else $error("write during reset pulse");
   property p_mirror;
      $changed(config_regs_o) |-> write_strobe_o || strap_operation_mode_o
                                  || $past(strap_operation_mode_o);
   endproperty
   a_mirror: assert property (p_mirror) else $error("register changed without a write");
   property p_addr; $changed(write_addr_o) |-> write_strobe_o; endproperty
   a_addr: assert property (p_addr) else $error("write address moved without a write");
endmodule : dac_serial_config_port_chk

bind dac_serial_config_port dac_serial_config_port_chk #(.NUM_REGS(NUM_REGS)) i_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
   .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
   .reset_or_pin_mode_select_i(reset_or_pin_mode_select_i), .config_regs_o(config_regs_o),
   .lsb_first_order_select_o(lsb_first_order_select_o),
   .strap_operation_mode_o(strap_operation_mode_o), .write_strobe_o(write_strobe_o),
   .write_addr_o(write_addr_o));
`default_nettype wire

// ===== test/host_model.sv
// host controller model for the three-wire link
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // link pins
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      sdio_o,
   output logic      pin_o,
   // device side of the data pin
   input  wire logic dev_sdio_i,
   input  wire logic dev_oe_n_i
);
   logic drv;
   logic en;
   // one shared pin, released level inverted
   assign sdio_o = !dev_oe_n_i ? dev_sdio_i : (en ? drv : ~drv);
   initial begin
      sclk_o = 0;
      cs_n_o = 0;
      pin_o = 0;
      drv = 0;
      en = 0;
      // one deselect edge clears the link sequencing and data pin drive at start, not the register file
      #1;
      cs_n_o = 1;
   end
   // pulse high 100 ns then low
   task automatic pulse_pin;
      pin_o = 1;
      #100;
      pin_o = 0;
   endtask : pulse_pin
   task automatic xfer(input logic [7:0] ins, input int nb, input logic [31:0] wd,
                       input bit lsb, input int stop, input bit pp, output logic [31:0] rd);
      logic [7:0] b;
      int n;
      int i;
      // instruction then one to four bytes
      n = (stop > 0) ? stop : 8 * (nb + 1);
      rd = '0;
      cs_n_o = 0;
      #80;
      for (int k = 0; k < n; k++) begin
         b = (k < 8) ? ins : wd[8 * (k / 8 - 1) +: 8];
         i = lsb ? k % 8 : 7 - k % 8;
         en = !(ins[7] && k >= 8);
         // set while clock low, sample on rise
         if (en) drv = b[i];
         #80;
         sclk_o = 1;
         if (!en) begin
            drv = sdio_o;
            rd[8 * (k / 8 - 1) + i] = sdio_o;
         end
         #80;
         sclk_o = 0;
      end
      #80;
      if (pp) begin
         pulse_pin();
         #80;
      end else begin
         cs_n_o = 1;
         en = 0;
         #160;
      end
   endtask : xfer
endmodule : host_model
`default_nettype wire

// ===== test/tb_dac_serial_config_port.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_dac_serial_config_port
   import serial_port_pkg::*;
;
   logic             clk, reset_n, sclk, cs_n, sdio, pin, dev_sdio, dev_oe_n;
   logic             lsb_sel, strap, wstb;
   logic [31:0][7:0] regs;
   logic [4:0]       waddr;
   logic [31:0]      rd;
   int               fails = 0, n_checks = 0, nstb = 0, base;
   dac_serial_config_port i_dut (.clk_i(clk), .reset_n_i(reset_n), .spi_sclk_i(sclk),
      .spi_cs_n_i(cs_n), .sdio_i(sdio), .sdio_o(dev_sdio), .sdio_oe_n_o(dev_oe_n),
      .reset_or_pin_mode_select_i(pin), .config_regs_o(regs),
      .lsb_first_order_select_o(lsb_sel), .strap_operation_mode_o(strap),
      .write_strobe_o(wstb), .write_addr_o(waddr));
   host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(sdio), .pin_o(pin),
      .dev_sdio_i(dev_sdio), .dev_oe_n_i(dev_oe_n));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (wstb === 1'b1) nstb <= nstb + 1;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic go(input logic [7:0] ins, input int nb, input logic [31:0] wd,
                     input bit lsb, input int stop, input bit pp);
      @(negedge clk);
      #3;
      i_host.xfer(ins, nb, wd, lsb, stop, pp, rd);
   endtask : go
   task automatic tally_and_finish;
      if (fails == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic t_write;
      base = nstb;
      go(8'h65, 4, 32'h44332211, 0, 0, 0);
      chk("regs5to2", 32'h11223344, regs[5:2]);
      chk("strobes", 4, nstb - base);
      chk("waddr", 2, waddr);
   endtask : t_write
   task automatic t_read;
      go(8'hc4, 3, 0, 0, 0, 0);
      chk("rd", 32'h00443322, rd);
      chk("oe_n", 1, dev_oe_n);
   endtask : t_read
   task automatic t_cs_abort;
      base = nstb;
      go(8'h3f, 2, 32'hbbaa, 0, 20, 0);
      chk("regs31to30", 16'haa00, regs[31:30]);
      chk("strobes", 1, nstb - base);
   endtask : t_cs_abort
   task automatic t_pin_abort;
      base = nstb;
      go(8'h0a, 1, 32'h5a, 0, 12, 1);
      chk("cleared", 0, regs[5:2]);
      chk("strobes", 0, nstb - base);
      go(8'h0a, 1, 32'h5a, 0, 0, 0);
      chk("reg10", 8'h5a, regs[10]);
   endtask : t_pin_abort
   task automatic t_lsb;
      go(8'h00, 1, 32'h40, 0, 0, 0);
      chk("lsb_sel", 1, lsb_sel);
      go(8'h3e, 2, 32'hc3b2, 1, 0, 0);
      chk("regs31to30", 16'hc3b2, regs[31:30]);
      go(8'hbe, 2, 0, 1, 0, 0);
      chk("rd", 32'hc3b2, rd);
   endtask : t_lsb
   task automatic t_soft;
      go(8'h00, 1, 32'h60, 1, 0, 0);
      chk("regs31to30", 0, regs[31:30]);
      chk("reg0", 8'h40, regs[0]);
   endtask : t_soft
   initial begin
      reset_n = 0;
      repeat (20) @(negedge clk);
      reset_n = 1;
      i_host.pulse_pin();
      #200;
      chk("mirror", 0, regs[3:0]);
      chk("strap", 0, strap);
      t_write();
      t_read();
      t_cs_abort();
      t_pin_abort();
      t_lsb();
      t_soft();
      tally_and_finish();
   end
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
endmodule : tb_dac_serial_config_port
`default_nettype wire
